/* File: common/serial_cfg_map.svh */
// offsets, field positions, reset values and fixed codes of the serial configuration registers
`ifndef SERIAL_CFG_MAP_SVH
`define SERIAL_CFG_MAP_SVH
`define OFS_SERIAL_PROTOCOL_CONFIG 8'h3D
`define OFS_PRODUCT_IDENTIFIER 8'h3E
`define OFS_BUS_SLAVE_ADDRESS 8'h3F
`define POS_STATUS_FORMAT 7
`define POS_DATA_WIDTH 6
`define POS_CRC_LEN_HI 5
`define POS_CRC_LEN_LO 4
`define POS_SEED_HI 3
`define POS_SEED_LO 0
`define RST_SERIAL_PROTOCOL_CONFIG 8'h00
`define RST_PRODUCT_IDENTIFIER 8'h00
`define RST_BUS_SLAVE_ADDRESS 8'h00
`define UNPROGRAMMED_VALUE 8'h00
`define ADDR_ALIAS_VALUE 8'h80
`define DEFAULT_SLAVE_ADDRESS 7'h60
`define DEFAULT_ADDRESS_READ 8'h60
// arbitrary neutral identity code
`define PRODUCT_ID_CODE 8'h5A
`define SEED8_DEFAULT 8'hFF
`define SEED8_UPPER 4'hF
`define SEED4_DEFAULT 4'hA
`define SEED3_DEFAULT 3'h7
`define WIDTH_NARROW 5'h0C
`define WIDTH_WIDE 5'h10
`endif

/* File: common/serial_cfg_pkg.sv */
// types shared by the serial configuration register bank
package serial_cfg_pkg;
  typedef enum logic [1:0] {
    CRC_LEN_8 = 2'h0,
    CRC_LEN_4 = 2'h1,
    CRC_LEN_3A = 2'h2,
    CRC_LEN_3B = 2'h3
  } crc_len_t;
  typedef enum logic [1:0] {
    IF_SPI = 2'h0,
    IF_I2C = 2'h1,
    IF_DSI3 = 2'h2,
    IF_PSI5 = 2'h3
  } if_mode_t;
  typedef enum logic [1:0] {
    POLY_8 = 2'h0,
    POLY_4 = 2'h1,
    POLY_3 = 2'h2
  } crc_poly_t;
  typedef struct packed {
    logic [7:0] protocol_config;
    logic [7:0] product_identifier;
    logic [7:0] slave_address;
    logic [7:0] read_data;
    logic read_valid;
    crc_poly_t active_poly;
    logic [7:0] active_seed;
    logic active_status_format;
    logic active_data_width;
    logic array_parity;
  } cfg_state_t;
endpackage

/* File: core/crc_setting_decode.sv */
// decode of crc length and seed fields into polynomial and seed
`timescale 1ns/1ps
`include "serial_cfg_map.svh"
module crc_setting_decode (
  // fields
  input wire logic [1:0] crc_length_select,
  input wire logic [3:0] crc_seed_field,
  // decoded crc setting
  output serial_cfg_pkg::crc_poly_t poly,
  output logic [7:0] seed
);
  import serial_cfg_pkg::*;
  logic seed_zero;
  assign seed_zero = (crc_seed_field == 4'h0);
  always_comb begin
    poly = POLY_3;
    seed = {5'h00, crc_seed_field[2:0]}; // RQ5
    unique case (crc_length_select)
      CRC_LEN_8: begin
        poly = POLY_8; // RQ3
        seed = seed_zero ? `SEED8_DEFAULT : {`SEED8_UPPER, crc_seed_field}; // RQ4 RQ5
      end
      CRC_LEN_4: begin
        poly = POLY_4; // RQ3
        seed = seed_zero ? {4'h0, `SEED4_DEFAULT} : {4'h0, crc_seed_field}; // RQ4 RQ5
      end
      CRC_LEN_3A, CRC_LEN_3B: begin
        poly = POLY_3; // RQ3
        seed = seed_zero ? {5'h00, `SEED3_DEFAULT} : {5'h00, crc_seed_field[2:0]}; // RQ4 RQ5
      end
    endcase
  end
endmodule

/* File: core/serial_if_config_regs.sv */
// serial interface configuration registers of the sensor
// What this block does
// [RQ1] status-format bit set picks alternate status scheme
// [RQ2] data-width bit: 0 gives 12, 1 gives 16
// [RQ3] length field selects one of three CRC polynomials
// [RQ4] zero seed field uses per-length default seed
// [RQ5] non-zero seed field forms the seed directly
// [RQ6] new polynomial applies from next SPI command
// [RQ7] new seed applies from next SPI command
// [RQ8] SPI fields inert outside SPI mode
// [RQ9] all three registers accessible in every mode
// [RQ10] registers covered by array error detection
// [RQ11] zero product identifier reads fixed identity code
// [RQ12] zero or 0x80 address gives 0x60
// [RQ13] otherwise low seven bits form address
// [RQ14] acknowledge only matching I2C address byte
`timescale 1ns/1ps
`include "serial_cfg_map.svh"
module serial_if_config_regs (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // interface mode
  input serial_cfg_pkg::if_mode_t IF_MODE,
  // register access from the protocol engines
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // spi command framing
  input wire logic SPI_CMD_START,
  // active spi settings
  output logic SPI_STATUS_ALT,
  output logic [4:0] SPI_DATA_BITS,
  output serial_cfg_pkg::crc_poly_t SPI_CRC_POLY,
  output logic [7:0] SPI_CRC_SEED,
  // i2c address match
  input wire logic I2C_ADDR_BYTE_VALID,
  input wire logic [6:0] I2C_ADDR_FIELD,
  output logic I2C_ADDR_ACK,
  output logic [6:0] I2C_SLAVE_ADDR,
  // array error detection
  output logic ARRAY_PARITY_ERROR
);
  import serial_cfg_pkg::*;
  cfg_state_t state;
  cfg_state_t next_state;
  crc_poly_t dec_poly;
  logic [7:0] dec_seed;
  logic [6:0] eff_addr;
  logic is_spi;

  ////////////////////////////////////////////////////////////////////////////
  // decode of pending crc setting
  crc_setting_decode crc_dec (
    .crc_length_select(state.protocol_config[`POS_CRC_LEN_HI:`POS_CRC_LEN_LO]),
    .crc_seed_field(state.protocol_config[`POS_SEED_HI:`POS_SEED_LO]),
    .poly(dec_poly),
    .seed(dec_seed)
  );

  assign is_spi = (IF_MODE == IF_SPI);
  always_comb begin
    if ((state.slave_address == `UNPROGRAMMED_VALUE) || (state.slave_address == `ADDR_ALIAS_VALUE)) begin
      eff_addr = `DEFAULT_SLAVE_ADDRESS; // RQ12
    end else begin
      eff_addr = state.slave_address[6:0]; // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state = state;
    next_state.read_valid = 1'b0;
    if (REG_WR) begin // RQ9
      unique case (REG_ADDR)
        `OFS_SERIAL_PROTOCOL_CONFIG: next_state.protocol_config = REG_WDATA;
        `OFS_PRODUCT_IDENTIFIER: next_state.product_identifier = REG_WDATA;
        `OFS_BUS_SLAVE_ADDRESS: next_state.slave_address = REG_WDATA;
        default: begin
        end
      endcase
      next_state.array_parity = ^{next_state.protocol_config, next_state.product_identifier,
        next_state.slave_address}; // RQ10
    end
    if (REG_RD) begin // RQ9
      next_state.read_valid = 1'b1;
      unique case (REG_ADDR)
        `OFS_SERIAL_PROTOCOL_CONFIG: next_state.read_data = state.protocol_config;
        `OFS_PRODUCT_IDENTIFIER: next_state.read_data =
          (state.product_identifier == `UNPROGRAMMED_VALUE) ? `PRODUCT_ID_CODE : state.product_identifier; // RQ11
        `OFS_BUS_SLAVE_ADDRESS: next_state.read_data =
          ((state.slave_address == `UNPROGRAMMED_VALUE) || (state.slave_address == `ADDR_ALIAS_VALUE)) ?
          `DEFAULT_ADDRESS_READ : state.slave_address; // RQ12 RQ13
        default: next_state.read_data = 8'h00;
      endcase
    end
    if (is_spi && SPI_CMD_START) begin // RQ8
      next_state.active_poly = dec_poly; // RQ6
      next_state.active_seed = dec_seed; // RQ7
      next_state.active_status_format = state.protocol_config[`POS_STATUS_FORMAT]; // RQ1
      next_state.active_data_width = state.protocol_config[`POS_DATA_WIDTH]; // RQ2
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= '{protocol_config: `RST_SERIAL_PROTOCOL_CONFIG, product_identifier: `RST_PRODUCT_IDENTIFIER,
        slave_address: `RST_BUS_SLAVE_ADDRESS, read_data: 8'h00, read_valid: 1'b0, active_poly: POLY_8,
        active_seed: `SEED8_DEFAULT, active_status_format: 1'b0, active_data_width: 1'b0, array_parity: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign REG_RDATA = state.read_data;
  assign REG_RVALID = state.read_valid;
  assign SPI_STATUS_ALT = state.active_status_format; // RQ1
  assign SPI_DATA_BITS = state.active_data_width ? `WIDTH_WIDE : `WIDTH_NARROW; // RQ2
  assign SPI_CRC_POLY = state.active_poly;
  assign SPI_CRC_SEED = state.active_seed;
  assign I2C_SLAVE_ADDR = eff_addr;
  assign I2C_ADDR_ACK = I2C_ADDR_BYTE_VALID && (IF_MODE == IF_I2C) && (I2C_ADDR_FIELD == eff_addr); // RQ14
  assign ARRAY_PARITY_ERROR = state.array_parity != ^{state.protocol_config, state.product_identifier,
    state.slave_address}; // RQ10

  ////////////////////////////////////////////////////////////////////////////
  // checks
  crc_hold_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ6
    !(is_spi && SPI_CMD_START) |=> $stable(SPI_CRC_POLY)) else $error("crc polynomial changed mid command");
  seed_hold_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ7
    !(is_spi && SPI_CMD_START) |=> $stable(SPI_CRC_SEED)) else $error("crc seed changed mid command");
  seed_take_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ4
    (is_spi && SPI_CMD_START && state.protocol_config[5:0] == 6'h00) |=> SPI_CRC_SEED == 8'hFF)
    else $error("default 8-bit seed not applied");
  poly_take_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ3
    (is_spi && SPI_CMD_START && state.protocol_config[5]) |=> SPI_CRC_POLY == POLY_3)
    else $error("3-bit polynomial not applied");
  mode_inert_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ8
    !is_spi |=> $stable(SPI_DATA_BITS) && $stable(SPI_STATUS_ALT) && $stable(SPI_CRC_POLY) && $stable(SPI_CRC_SEED))
    else $error("spi setting moved outside spi");
  width_map_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ2
    (is_spi && SPI_CMD_START && state.protocol_config[6]) |=> SPI_DATA_BITS == 5'h10)
    else $error("wide data field not applied");
  ident_read_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ11
    (REG_RD && REG_ADDR == `OFS_PRODUCT_IDENTIFIER && state.product_identifier == `UNPROGRAMMED_VALUE)
    |=> REG_RVALID && REG_RDATA == `PRODUCT_ID_CODE)
    else $error("unprogrammed identifier read wrong");
  addr_alias_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ12
    (state.slave_address == 8'h80) |-> I2C_SLAVE_ADDR == 7'h60) else $error("alias address not defaulted");
  addr_ack_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ14
    I2C_ADDR_ACK |-> I2C_ADDR_FIELD == I2C_SLAVE_ADDR) else $error("ack without address match");
  parity_ok_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ10
    REG_WR |=> !ARRAY_PARITY_ERROR) else $error("array check flags fresh write");

  ////////////////////////////////////////////////////////////////////////////
  // helpers for the setting checks
  logic start_taken;
  logic [1:0] len_field;
  logic [3:0] seed_field;
  assign start_taken = is_spi && SPI_CMD_START;
  assign len_field = state.protocol_config[`POS_CRC_LEN_HI:`POS_CRC_LEN_LO];
  assign seed_field = state.protocol_config[`POS_SEED_HI:`POS_SEED_LO];

  ////////////////////////////////////////////////////////////////////////////
  // checks of the crc and format settings
  poly_len8_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ3
    (start_taken && len_field == CRC_LEN_8)
    |=> SPI_CRC_POLY == POLY_8)
    else $error("8-bit polynomial not applied");
  poly_len4_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ3
    (start_taken && len_field == CRC_LEN_4)
    |=> SPI_CRC_POLY == POLY_4)
    else $error("4-bit polynomial not applied");
  seed_def4_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ4
    (start_taken && len_field == CRC_LEN_4 && seed_field == 4'h0)
    |=> SPI_CRC_SEED == {4'h0, `SEED4_DEFAULT})
    else $error("default 4-bit seed not applied");
  seed_def3_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ4
    (start_taken && len_field[1] && seed_field == 4'h0)
    |=> SPI_CRC_SEED == {5'h00, `SEED3_DEFAULT})
    else $error("default 3-bit seed not applied");
  seed_form8_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ5
    (start_taken && len_field == CRC_LEN_8 && seed_field != 4'h0)
    |=> SPI_CRC_SEED == {`SEED8_UPPER, $past(seed_field)})
    else $error("8-bit seed not formed from field");
  seed_form4_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ5
    (start_taken && len_field == CRC_LEN_4 && seed_field != 4'h0)
    |=> SPI_CRC_SEED == {4'h0, $past(seed_field)})
    else $error("4-bit seed not formed from field");
  seed_form3_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ5
    (start_taken && len_field[1] && seed_field != 4'h0)
    |=> SPI_CRC_SEED == {5'h00, $past(seed_field[2:0])})
    else $error("3-bit seed not formed from field");
  status_take_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ1
    start_taken
    |=> SPI_STATUS_ALT == $past(state.protocol_config[`POS_STATUS_FORMAT]))
    else $error("status scheme not applied");
  width_narrow_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ2
    (start_taken && !state.protocol_config[`POS_DATA_WIDTH])
    |=> SPI_DATA_BITS == `WIDTH_NARROW)
    else $error("narrow data field not applied");
  reset_setting_a: assert property (@(posedge CLOCK) // RQ4
    SYS_RST
    |=> SPI_CRC_SEED == `SEED8_DEFAULT && SPI_CRC_POLY == POLY_8 && !REG_RVALID)
    else $error("reset settings wrong");

  ////////////////////////////////////////////////////////////////////////////
  // checks of register access and of the i2c address and acknowledge
  store_cfg_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    (REG_WR && REG_ADDR == `OFS_SERIAL_PROTOCOL_CONFIG)
    |=> state.protocol_config == $past(REG_WDATA))
    else $error("config write not stored");
  store_ident_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    (REG_WR && REG_ADDR == `OFS_PRODUCT_IDENTIFIER)
    |=> state.product_identifier == $past(REG_WDATA))
    else $error("identifier write not stored");
  store_addr_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    (REG_WR && REG_ADDR == `OFS_BUS_SLAVE_ADDRESS)
    |=> state.slave_address == $past(REG_WDATA))
    else $error("address write not stored");
  read_pulse_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    REG_RD
    |=> REG_RVALID)
    else $error("read not answered");
  read_idle_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    !REG_RD
    |=> !REG_RVALID)
    else $error("read answer without read");
  read_cfg_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    (REG_RD && REG_ADDR == `OFS_SERIAL_PROTOCOL_CONFIG)
    |=> REG_RDATA == $past(state.protocol_config))
    else $error("config read wrong");
  read_unmapped_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    (REG_RD && !(REG_ADDR inside {`OFS_SERIAL_PROTOCOL_CONFIG, `OFS_PRODUCT_IDENTIFIER, `OFS_BUS_SLAVE_ADDRESS}))
    |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  ident_stored_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ11
    (REG_RD && REG_ADDR == `OFS_PRODUCT_IDENTIFIER && state.product_identifier != `UNPROGRAMMED_VALUE)
    |=> REG_RDATA == $past(state.product_identifier))
    else $error("stored identifier read wrong");
  addr_stored_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ13
    (REG_RD && REG_ADDR == `OFS_BUS_SLAVE_ADDRESS && state.slave_address != `UNPROGRAMMED_VALUE &&
    state.slave_address != `ADDR_ALIAS_VALUE) |=> REG_RDATA == $past(state.slave_address))
    else $error("stored address read wrong");
  addr_zero_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ12
    (state.slave_address == `UNPROGRAMMED_VALUE)
    |-> I2C_SLAVE_ADDR == `DEFAULT_SLAVE_ADDRESS)
    else $error("unprogrammed address not defaulted");
  addr_low_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ13
    (state.slave_address != `UNPROGRAMMED_VALUE && state.slave_address != `ADDR_ALIAS_VALUE)
    |-> I2C_SLAVE_ADDR == state.slave_address[6:0])
    else $error("address not taken from low bits");
  ack_mode_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ14
    (IF_MODE != IF_I2C)
    |-> !I2C_ADDR_ACK)
    else $error("ack outside i2c mode");
  ack_match_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ14
    (I2C_ADDR_BYTE_VALID && IF_MODE == IF_I2C && I2C_ADDR_FIELD == I2C_SLAVE_ADDR)
    |-> I2C_ADDR_ACK)
    else $error("matching address not acknowledged");
endmodule

/* File: tb/host_bus_model.sv */
// host controller model issuing register writes and reads
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input wire logic clk,
  // register access
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // one-cycle write strobe, data scrambled once released
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // one-cycle read strobe, answer taken one cycle later
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
    v = rvalid;
  endtask
endmodule

/* File: tb/serial_if_config_regs_test.sv */
// self-checking bench of the serial configuration registers
`timescale 1ns/1ps
`include "serial_cfg_map.svh"
module serial_if_config_regs_test;
  import serial_cfg_pkg::*;
  logic clk, rst, start, bvalid, wr, rd, rvalid, alt, ack, perr, v;
  if_mode_t mode;
  crc_poly_t poly;
  logic [6:0] field, saddr;
  logic [7:0] addr, wdata, rdata, seed, got, es, mask;
  logic [4:0] bits;
  logic [1:0] ep;
  int n_mismatch, num_checks, cycles;
  serial_if_config_regs i_dut (.CLOCK(clk), .SYS_RST(rst), .IF_MODE(mode), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .SPI_CMD_START(start),
    .SPI_STATUS_ALT(alt), .SPI_DATA_BITS(bits), .SPI_CRC_POLY(poly), .SPI_CRC_SEED(seed),
    .I2C_ADDR_BYTE_VALID(bvalid), .I2C_ADDR_FIELD(field), .I2C_ADDR_ACK(ack), .I2C_SLAVE_ADDR(saddr),
    .ARRAY_PARITY_ERROR(perr));
  host_bus_model i_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_host.rd_reg(a, got, v);
    check({what, " valid"}, {7'h00, v}, 8'h01);
    check(what, got, exp);
  endtask
  task automatic cmd;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
  endtask
  task automatic spi(input logic [1:0] p, input logic [7:0] s, input logic [7:0] m, input logic a, input logic [4:0] b);
    #1;
    check("poly", {6'h00, poly}, {6'h00, p});
    check("seed", seed & m, s);
    check("status", {7'h00, alt}, {7'h00, a});
    check("width", {3'h0, bits}, {3'h0, b});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1;
    start = 1'b0;
    bvalid = 1'b0;
    field = 7'h00;
    mode = IF_SPI;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(`OFS_SERIAL_PROTOCOL_CONFIG, 8'h00, "cfg reset");
    rchk(`OFS_PRODUCT_IDENTIFIER, `PRODUCT_ID_CODE, "id unprog");
    rchk(`OFS_BUS_SLAVE_ADDRESS, 8'h60, "addr unprog");
    rchk(8'h3C, 8'h00, "unmapped");
    spi(2'h0, 8'hFF, 8'hFF, 1'b0, 5'h0C);
    $display("reset test done");
    ep = 2'h0;
    es = 8'hFF;
    mask = 8'hFF;
    for (int l = 0; l < 4; l++) begin
      for (int s = 0; s < 16; s += 5) begin
        i_host.wr_reg(`OFS_SERIAL_PROTOCOL_CONFIG, {2'b00, l[1:0], s[3:0]});
        spi(ep, es, mask, 1'b0, 5'h0C);
        ep = (l == 0) ? 2'h0 : (l == 1) ? 2'h1 : 2'h2;
        mask = (l == 0) ? 8'hFF : (l == 1) ? 8'h0F : 8'h07;
        es = (s == 0) ? ((l == 0) ? 8'hFF : (l == 1) ? 8'h0A : 8'h07) : ({4'hF, s[3:0]} & mask);
        cmd();
        spi(ep, es, mask, 1'b0, 5'h0C);
      end
    end
    $display("crc test done");
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      mode <= if_mode_t'(m);
      i_host.wr_reg(`OFS_SERIAL_PROTOCOL_CONFIG, 8'hC0);
      rchk(`OFS_SERIAL_PROTOCOL_CONFIG, 8'hC0, "cfg other mode");
      cmd();
      spi(ep, es, mask, 1'b0, 5'h0C);
    end
    @(posedge clk);
    mode <= IF_SPI;
    cmd();
    spi(2'h0, 8'hFF, 8'hFF, 1'b1, 5'h10);
    $display("mode test done");
    @(posedge clk);
    mode <= IF_I2C;
    i_host.wr_reg(`OFS_PRODUCT_IDENTIFIER, 8'h33);
    rchk(`OFS_PRODUCT_IDENTIFIER, 8'h33, "id stored");
    i_host.wr_reg(`OFS_BUS_SLAVE_ADDRESS, 8'h80);
    rchk(`OFS_BUS_SLAVE_ADDRESS, 8'h60, "addr alias");
    @(posedge clk);
    bvalid <= 1'b1;
    field <= 7'h60;
    @(posedge clk);
    #1;
    check("ack alias", {7'h00, ack}, 8'h01);
    i_host.wr_reg(`OFS_BUS_SLAVE_ADDRESS, 8'hA5);
    rchk(`OFS_BUS_SLAVE_ADDRESS, 8'hA5, "addr stored");
    check("slave addr", {1'b0, saddr}, 8'h25);
    check("ack old", {7'h00, ack}, 8'h00);
    @(posedge clk);
    field <= 7'h25;
    @(posedge clk);
    #1;
    check("ack match", {7'h00, ack}, 8'h01);
    @(posedge clk);
    mode <= IF_SPI;
    @(posedge clk);
    #1;
    check("ack spi", {7'h00, ack}, 8'h00);
    check("parity", {7'h00, perr}, 8'h00);
    $display("address test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    spi(2'h0, 8'hFF, 8'hFF, 1'b0, 5'h0C);
    check("addr reset", {1'b0, saddr}, 8'h60);
    rchk(`OFS_PRODUCT_IDENTIFIER, `PRODUCT_ID_CODE, "id reset");
    $display("second reset test done");
    final_report();
  end
endmodule
